// [inc/mrs_defines.vh]
// Timing constants and reset values for motor restart supervision.
`ifndef MRS_DEFINES_VH
`define MRS_DEFINES_VH
`define MRS_CLK_MHZ           250
`define MRS_TICK_US           1000
`define MRS_TICK_CYCLES       (`MRS_TICK_US * `MRS_CLK_MHZ)
`define MRS_HOT_PERMIL        10'd500
`define MRS_LOWV_MS           100
`define MRS_REAC_WIN_MS       5000
`define MRS_ROTOR_STOP_S      3000
`define MRS_ROTOR_STOP_MS     (`MRS_ROTOR_STOP_S * 1000)
`define MRS_RESID_LIMIT_MV    16'd10000
`define MRS_AR_IDLE           3'd0
`define MRS_AR_MEDIUM         3'd1
`define MRS_AR_SHED           3'd2
`define MRS_AR_CLOSE          3'd3
`endif

// [core/mrs_supervisor.v]
// Motor start, anti-backspin, dip classification and automatic restart supervision.
// Overview of operation
// [R1] Thermal state above half means hot start.
// [R2] Run time counts while breaker stays closed.
// [R3] Locked rotor element works only when enabled.
// [R4] Residual wiring uses voltage check, else timer.
// [R5] Residual wiring: stop delay after voltage low.
// [R6] Other wiring: stop delay from trip, blocks restart.
// [R7] Dips classed short, medium, long by settings.
// [R8] Short dip while running forces reacceleration, no trip.
// [R9] Dip over 100 ms inhibits stall on recovery.
// [R10] Reacceleration window 5 s keeps start protection.
// [R11] Reacceleration off during start, needs breaker status.
// [R12] Auto restart armed only by dip trip.
// [R13] Nonzero medium window starts after dip trip.
// [R14] Supply back in window closes, else deactivate.
// [R15] Nonzero stagger delay postpones close order.
// [R16] Timers count ticks, clear when cause withdrawn.
// [R17] Trip when voltage not restored by short time.
//
// The implementer's own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
`include "mrs_defines.vh"
module mrs_supervisor #(
  parameter integer TICK_CYCLES   = `MRS_TICK_CYCLES,
  parameter integer ROTOR_STOP_MS = `MRS_ROTOR_STOP_MS,
  parameter integer LOWV_MS       = `MRS_LOWV_MS,
  parameter integer REAC_WIN_MS   = `MRS_REAC_WIN_MS,
  parameter integer TW            = 24
) (
  input  wire          ref_clk,
  input  wire          reset_n,
  input  wire [9:0]    thermal_permil,
  input  wire          breaker_closed_pin,
  input  wire          starting,
  input  wire [15:0]   phase_current,
  input  wire [15:0]   start_current_threshold,
  input  wire [TW-1:0] stall_delay,
  input  wire          locked_rotor_enable,
  input  wire          protection_trip,
  input  wire          transformer_wiring_select,
  input  wire [15:0]   residual_voltage_mv,
  input  wire [15:0]   residual_voltage_limit,
  input  wire [TW-1:0] rotor_stop_delay,
  input  wire          supply_below_dip,
  input  wire          supply_restored,
  input  wire [TW-1:0] short_dip_time,
  input  wire [TW-1:0] medium_restart_window,
  input  wire [TW-1:0] staggered_restart_delay,
  input  wire          auto_restart_enable,
  input  wire          write_strobe,
  input  wire          read_strobe,
  input  wire [3:0]    address,
  input  wire [31:0]   write_data,
  output reg  [31:0]   read_data,
  output reg           hot_start,
  output reg           locked_rotor_trip,
  output reg           restart_blocked,
  output reg           dip_trip,
  output reg           force_reaccel,
  output reg           stall_inhibit,
  output reg           reaccel_seen,
  output reg           close_order,
  output reg  [1:0]    dip_class
);
  localparam [3:0] A_RUNTIME = 4'h0;
  localparam [3:0] A_STATUS  = 4'h1;
  localparam [3:0] A_CLEAR   = 4'h2;

  // Three-stage pin synchroniser; the second and third stages must agree.
  reg [2:0] brk_sync;
  reg       brk;
  always @(posedge ref_clk or negedge reset_n)
    if (!reset_n)
    begin
      brk_sync <= 3'b000;
      brk      <= 1'b0;
    end
    else
    begin
      brk_sync <= {brk_sync[1:0], breaker_closed_pin};
      if (brk_sync[1] == brk_sync[2])
        brk <= brk_sync[2];
    end

  // Millisecond tick shared by every delay timer.
  reg [31:0] pre;
  wire       tick = (pre == TICK_CYCLES - 1);
  always @(posedge ref_clk or negedge reset_n)
    if (!reset_n)
      pre <= 32'h0;
    else
      pre <= tick ? 32'h0 : pre + 32'h1; // [R16]

  reg [31:0] run_time;
  reg        brk_q;
  reg [TW-1:0] lr_cnt, stop_cnt, dip_cnt, win_cnt, reac_cnt, ar_cnt;
  reg        tripped_q, was_running, dip_long, reac_arm;
  reg [2:0]  ar_state;
  wire       trip_rise = protection_trip & ~tripped_q;
  wire       resid_low = residual_voltage_mv < residual_voltage_limit;
  wire       stop_run  = transformer_wiring_select ? resid_low : 1'b1; // [R4]
  wire       lr_cond   = locked_rotor_enable & (phase_current > start_current_threshold);

  always @(posedge ref_clk or negedge reset_n)
    if (!reset_n)
    begin
      hot_start         <= 1'b0;
      run_time          <= 32'h0;
      brk_q             <= 1'b0;
      lr_cnt            <= {TW{1'b0}};
      locked_rotor_trip <= 1'b0;
      stop_cnt          <= {TW{1'b0}};
      restart_blocked   <= 1'b0;
      tripped_q         <= 1'b0;
      dip_cnt           <= {TW{1'b0}};
      dip_trip          <= 1'b0;
      dip_class         <= 2'b00;
      was_running       <= 1'b0;
      dip_long          <= 1'b0;
      force_reaccel     <= 1'b0;
      stall_inhibit     <= 1'b0;
      reac_arm          <= 1'b0;
      reac_cnt          <= {TW{1'b0}};
      reaccel_seen      <= 1'b0;
      ar_state          <= `MRS_AR_IDLE;
      ar_cnt            <= {TW{1'b0}};
      win_cnt           <= {TW{1'b0}};
      close_order       <= 1'b0;
    end
    else
    begin
      tripped_q <= protection_trip;
      brk_q <= brk;
      if (thermal_permil > `MRS_HOT_PERMIL)
        hot_start <= 1'b1; // [R1]
      else if (thermal_permil < `MRS_HOT_PERMIL)
        hot_start <= 1'b0; // [R1]
      if (brk & ~brk_q)
        run_time <= 32'h0; // [R2]
      else if (brk & tick)
        run_time <= run_time + 32'h1; // [R2]
      // Locked rotor element timed by the stall delay.
      if (!lr_cond)
        lr_cnt <= {TW{1'b0}}; // [R3] [R16]
      else if (tick && lr_cnt != stall_delay)
        lr_cnt <= lr_cnt + 1'b1;
      locked_rotor_trip <= lr_cond & (lr_cnt == stall_delay); // [R3]
      // Anti-backspin: block from trip until rotor stop delay expires.
      if (trip_rise | dip_trip)
      begin
        restart_blocked <= 1'b1; // [R6]
        stop_cnt <= {TW{1'b0}};
      end
      else if (restart_blocked)
      begin
        if (!stop_run)
          stop_cnt <= {TW{1'b0}}; // [R5] [R16]
        else if (stop_cnt >= rotor_stop_delay)
          restart_blocked <= 1'b0; // [R6]
        else if (tick)
          stop_cnt <= stop_cnt + 1'b1; // [R5]
      end
      // Dip duration measurement and classification.
      force_reaccel <= 1'b0;
      dip_trip <= 1'b0;
      if (supply_below_dip)
      begin
        if (dip_cnt == {TW{1'b0}})
          was_running <= brk;
        if (tick && dip_cnt != {TW{1'b1}})
          dip_cnt <= dip_cnt + 1'b1;
        if (dip_cnt >= LOWV_MS)
          dip_long <= 1'b1;
        if (dip_cnt == short_dip_time && tick && brk)
        begin
          dip_trip <= 1'b1; // [R17]
          dip_class <= 2'd2; // [R7]
        end
        else if (dip_cnt < short_dip_time)
          dip_class <= 2'd1; // [R7]
      end
      else if (supply_restored && dip_cnt != {TW{1'b0}})
      begin
        dip_cnt <= {TW{1'b0}}; // [R16]
        dip_long <= 1'b0;
        if (dip_cnt < short_dip_time && was_running)
          force_reaccel <= 1'b1; // [R8]
        if (dip_long && brk && !starting && dip_cnt < short_dip_time)
        begin
          stall_inhibit <= 1'b1; // [R9] [R11]
          reac_arm <= 1'b1;
          reac_cnt <= {TW{1'b0}};
        end
      end
      // Reacceleration window.
      if (reac_arm)
      begin
        if (starting || !brk)
        begin
          reac_arm <= 1'b0; // [R11]
          stall_inhibit <= 1'b0;
        end
        else if (phase_current > start_current_threshold)
          reaccel_seen <= 1'b1; // [R10]
        if (tick)
          reac_cnt <= reac_cnt + 1'b1;
        if (reac_cnt >= REAC_WIN_MS)
        begin
          reac_arm <= 1'b0; // [R10]
          stall_inhibit <= 1'b0;
        end
      end
      else
        reaccel_seen <= 1'b0;
      // Automatic restart sequencer.
      close_order <= 1'b0;
      case (ar_state)
        `MRS_AR_IDLE:
          if (dip_trip && auto_restart_enable && medium_restart_window != {TW{1'b0}})
          begin
            ar_state <= `MRS_AR_MEDIUM; // [R12] [R13]
            win_cnt <= {TW{1'b0}};
            dip_class <= 2'd2;
          end
        `MRS_AR_MEDIUM:
          if (supply_restored && !supply_below_dip)
          begin
            ar_cnt <= {TW{1'b0}};
            ar_state <= (staggered_restart_delay != {TW{1'b0}}) ? `MRS_AR_SHED
                        : `MRS_AR_CLOSE; // [R14] [R15]
            if (staggered_restart_delay != {TW{1'b0}})
              dip_class <= 2'd3; // [R7]
          end
          else if (win_cnt >= medium_restart_window)
            ar_state <= `MRS_AR_IDLE; // [R14]
          else if (tick)
            win_cnt <= win_cnt + 1'b1;
        `MRS_AR_SHED:
          if (supply_below_dip)
            ar_state <= `MRS_AR_MEDIUM; // [R16]
          else if (ar_cnt >= staggered_restart_delay)
            ar_state <= `MRS_AR_CLOSE; // [R15]
          else if (tick)
            ar_cnt <= ar_cnt + 1'b1;
        `MRS_AR_CLOSE:
          if (!restart_blocked)
          begin
            close_order <= 1'b1; // [R14]
            ar_state <= `MRS_AR_IDLE;
          end
        default:
          ar_state <= `MRS_AR_IDLE;
      endcase
      // A disabled restart must never leave a close order behind.
      if (!auto_restart_enable)
      begin
        ar_state    <= `MRS_AR_IDLE; // [R12]
        close_order <= 1'b0;
      end
    end

  // Register port: run time and status, read data one cycle after the strobe.
  always @(posedge ref_clk or negedge reset_n)
    if (!reset_n)
      read_data <= 32'h0;
    else if (read_strobe)
    begin
      case (address)
        A_RUNTIME: read_data <= run_time;
        A_STATUS:  read_data <= {21'h0, ar_state, dip_class, restart_blocked,
                                 stall_inhibit, reaccel_seen, hot_start, brk, 1'b0};
        default:   read_data <= 32'h0;
      endcase
    end
    else
      read_data <= 32'h0;
endmodule

// [sim/mrs_checker.sv]
// Assertion checker bound to the supervisor ports.
`timescale 1ns/10ps
module mrs_checker (
  input wire        ref_clk,
  input wire        reset_n,
  input wire [9:0]  thermal_permil,
  input wire        locked_rotor_enable,
  input wire        auto_restart_enable,
  input wire        read_strobe,
  input wire [31:0] read_data,
  input wire        hot_start,
  input wire        locked_rotor_trip,
  input wire        restart_blocked,
  input wire        dip_trip,
  input wire        force_reaccel,
  input wire        close_order
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  sequence s_hot; (thermal_permil > 10'd500) [*4]; endsequence
  sequence s_cold; (thermal_permil < 10'd500) [*4]; endsequence
  AST_HOT: assert property (s_hot |-> hot_start)
    else $error("hot start missing");
  AST_COLD: assert property (s_cold |-> !hot_start)
    else $error("cold start shown as hot");
  AST_LOCK: assert property ((!locked_rotor_enable) [*4] |-> !locked_rotor_trip)
    else $error("locked rotor trip while disabled");
  AST_DIP_PULSE: assert property (dip_trip |=> !dip_trip)
    else $error("dip trip longer than one cycle");
  AST_DIP_BLOCK: assert property (dip_trip |-> ##[0:2] restart_blocked)
    else $error("restart not blocked after dip trip");
  AST_REACC: assert property (force_reaccel |-> !dip_trip ##1 !dip_trip)
    else $error("trip beside forced reacceleration");
  AST_CLOSE: assert property (close_order |->
    $past(auto_restart_enable) && !$past(restart_blocked) ##1 !close_order)
    else $error("close order while not allowed");
  AST_READ: assert property (read_data != 32'h0 |-> $past(read_strobe))
    else $error("read data outside answer cycle");
endmodule
bind mrs_supervisor mrs_checker u_checker (.ref_clk, .reset_n, .thermal_permil,
  .locked_rotor_enable, .auto_restart_enable, .read_strobe, .read_data, .hot_start,
  .locked_rotor_trip, .restart_blocked, .dip_trip, .force_reaccel, .close_order);

// [sim/mrs_breaker_model.sv]
// Breaker model: closes on a close order or manual command, opens on a trip.
`timescale 1ns/10ps
module mrs_breaker_model (
  input  wire ref_clk,
  input  wire manual_close,
  input  wire close_order,
  input  wire trip,
  output reg  breaker_closed_pin
);
  initial breaker_closed_pin = 1'b0;
  always @(posedge ref_clk)
  begin
    if (trip)
      breaker_closed_pin <= 1'b0;
    else if (close_order || manual_close)
      breaker_closed_pin <= 1'b1;
  end
endmodule

// [sim/mrs_supervisor_tb_top.sv]
// Self-checking bench for motor restart supervision.
`timescale 1ns/10ps
module mrs_supervisor_tb_top;
  reg         ref_clk, reset_n, man, rs, below, back, ar_en, lr_en;
  reg         st, ptrip, wsel;
  reg  [23:0] stopd, sdt, mwin, stag;
  reg  [9:0]  therm;
  reg  [15:0] cur;
  reg  [3:0]  addr;
  reg  [31:0] seed, r, t0;
  wire [31:0] rd;
  wire        brk, hot, lrt, blk, dtrip, frc, sinh, seen, cls;
  wire [1:0]  dcls;
  integer     num_errors, n_compared, k;
  integer     cyc = 0, n_cls = 0, n_dip = 0, n_frc = 0;
  mrs_supervisor #(.TICK_CYCLES(10), .LOWV_MS(3), .REAC_WIN_MS(50)) uut (
    .ref_clk(ref_clk), .reset_n(reset_n), .thermal_permil(therm),
    .breaker_closed_pin(brk), .starting(st), .phase_current(cur),
    .start_current_threshold(16'h8000), .stall_delay(24'd4),
    .locked_rotor_enable(lr_en), .protection_trip(ptrip),
    .transformer_wiring_select(wsel), .residual_voltage_mv(cur),
    .residual_voltage_limit(16'h2710), .rotor_stop_delay(stopd),
    .supply_below_dip(below), .supply_restored(back), .short_dip_time(sdt),
    .medium_restart_window(mwin), .staggered_restart_delay(stag),
    .auto_restart_enable(ar_en), .write_strobe(1'b0), .read_strobe(rs),
    .address(addr), .write_data(seed), .read_data(rd), .hot_start(hot),
    .locked_rotor_trip(lrt), .restart_blocked(blk), .dip_trip(dtrip),
    .force_reaccel(frc), .stall_inhibit(sinh), .reaccel_seen(seen),
    .close_order(cls), .dip_class(dcls));
  mrs_breaker_model brk_m (.ref_clk(ref_clk), .manual_close(man),
    .close_order(cls), .trip(dtrip), .breaker_closed_pin(brk));
  function [31:0] xs(input [31:0] s);
    reg [31:0] v;
    begin
      v = s ^ (s << 13);
      v = v ^ (v >> 17);
      xs = v ^ (v << 5);
    end
  endfunction
  function [31:0] in_range(input [31:0] v, input [31:0] lo, input [31:0] hi);
    in_range = (v >= lo && v <= hi) ? 32'h1 : 32'h0;
  endfunction
  task check(input [31:0] exp, input [31:0] got, input [8*12-1:0] what);
    begin
      n_compared = n_compared + 1;
      if (got !== exp)
      begin
        num_errors = num_errors + 1;
        $display("Error %0s expected %0h seen %0h", what, exp, got);
      end
    end
  endtask
  task complete_run;
    begin
      if (num_errors == 0 && n_compared > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  // Read data stand only in the cycle after the strobe, so sample there.
  task rd_reg(input [3:0] a, output [31:0] d);
    begin
      rs <= 1'b1;
      addr <= a;
      @(posedge ref_clk);
      rs <= 1'b0;
      #1 d = rd;
      @(posedge ref_clk);
    end
  endtask
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    n_cls <= n_cls + cls;
    n_dip <= n_dip + dtrip;
    n_frc <= n_frc + frc;
    if (cyc == 20000)
    begin
      num_errors = num_errors + 1;
      complete_run;
    end
  end
  initial
  begin
    seed = 32'h73fe;
    num_errors = 0;
    n_compared = 0;
    {man, rs, below, back, ar_en, lr_en} = 6'h0;
    {st, ptrip, wsel} = 3'h0;
    stopd = 24'd2;
    sdt = 24'd8;
    mwin = 24'd20;
    stag = 24'd6;
    therm = 10'h0;
    cur = 16'h0;
    addr = 4'h0;
    reset_n = 1'b0;
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    for (k = 0; k < 24; k = k + 1)
    begin
      seed = xs(seed);
      therm <= (k == 0) ? 10'd501 : (k == 1) ? 10'd499 : seed[9:0] | 10'h1;
      lr_en <= seed[10];
      cur <= seed[31:16];
      repeat (6) @(posedge ref_clk);
      check(32'(therm > 10'd500), 32'(hot), "hot start");
    end
    lr_en <= 1'b1;
    cur <= 16'hffff;
    repeat (60) @(posedge ref_clk);
    check(32'h1, 32'(lrt), "locked rotor");
    lr_en <= 1'b0;
    cur <= 16'h0;
    man <= 1'b1;
    @(posedge ref_clk);
    man <= 1'b0;
    repeat (20) @(posedge ref_clk);
    rd_reg(4'h0, t0);
    repeat (98) @(posedge ref_clk);
    rd_reg(4'h0, r);
    check(32'd10, r - t0, "run time");
    rd_reg(4'h1, r);
    check(32'h1, 32'(r[1]), "breaker");
    rd_reg(4'h9, r);
    check(32'h0, r, "unmapped");
    below <= 1'b1;
    repeat (50) @(posedge ref_clk);
    below <= 1'b0;
    back <= 1'b1;
    cur <= 16'hffff;
    repeat (40) @(posedge ref_clk);
    check(32'h1, n_frc, "reaccel");
    check(32'h0, n_dip, "no trip");
    check(32'h1, 32'(sinh), "stall inh");
    check(32'h1, 32'(seen), "reacc seen");
    check(32'h1, 32'(dcls), "short class");
    cur <= 16'h0;
    ar_en <= 1'b1;
    below <= 1'b1;
    back <= 1'b0;
    t0 = cyc;
    for (k = 0; k < 200 && n_dip == 0; k = k + 1)
      @(posedge ref_clk);
    check(32'h1, in_range(cyc - t0, 70, 95), "dip time");
    check(32'h1, 32'(blk), "dip blocked");
    check(32'h2, 32'(dcls), "medium class");
    repeat (30) @(posedge ref_clk);
    below <= 1'b0;
    back <= 1'b1;
    t0 = cyc;
    for (k = 0; k < 300 && n_cls == 0; k = k + 1)
      @(posedge ref_clk);
    check(32'h1, n_cls, "close");
    check(32'h1, in_range(cyc - t0, 60, 90), "stagger");
    check(32'h3, 32'(dcls), "long class");
    repeat (20) @(posedge ref_clk);
    below <= 1'b1;
    back <= 1'b0;
    repeat (400) @(posedge ref_clk);
    below <= 1'b0;
    back <= 1'b1;
    repeat (150) @(posedge ref_clk);
    check(32'h2, n_dip, "second dip");
    check(32'h1, n_cls, "late close");
    ptrip <= 1'b1;
    @(posedge ref_clk);
    ptrip <= 1'b0;
    repeat (3) @(posedge ref_clk);
    check(32'h1, 32'(blk), "trip block");
    repeat (40) @(posedge ref_clk);
    check(32'h0, 32'(blk), "stop timer");
    wsel <= 1'b1;
    cur <= 16'hffff;
    ptrip <= 1'b1;
    @(posedge ref_clk);
    ptrip <= 1'b0;
    repeat (60) @(posedge ref_clk);
    check(32'h1, 32'(blk), "resid high");
    cur <= 16'h0;
    repeat (40) @(posedge ref_clk);
    check(32'h0, 32'(blk), "resid low");
    complete_run;
  end
endmodule
